// File: dacc_control.sv
// dac control register with axi4-lite slave and channel enable decode
// Overview of operation
// [R1] bit 7 chan1 output enable, bit 6 chan0, bit 5 shared enable; all r/w.
// [R2] chan0 output enable at 1 turns on chan0 conversion and output drive.
// [R3] chan1 output enable at 1 turns on chan1 conversion and output drive.
// [R4] chan0 output enable at 0 keeps the chan0 analog output disabled.
// [R5] chan1 output enable at 0 keeps the chan1 analog output disabled.
// [R6] both output enables at 0 disable conversion in both channels.
// [R7] only chan0 enabled with shared enable 0 converts on chan0 only.
// [R8] only chan1 enabled with shared enable 0 converts on chan1 only.
// [R9] any output enable at 1 with shared enable 1 converts on both channels.
// [R10] low five bits ignore writes, read as 1; control bits reset to 0.
`timescale 1ns/1ps
`default_nettype none
module dacc_control
    import dacc_pkg::*;
(
    // clock and synchronous active-low reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // write address and write data channels
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // write response channel
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // read address and read data channels
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // decoded enables towards the analog side
    output dacc_enable_type            chan_enable
);
    // write side state
    logic                  aw_held;
    logic                  w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    // only byte lane 0 of the data word carries state
    logic [7:0]            w_byte;
    logic                  w_strb0;
    logic                  next_aw_held;
    logic                  next_w_held;
    logic [ADDR_WIDTH-1:0] next_aw_addr;
    logic [7:0]            next_w_byte;
    logic                  next_w_strb0;
    logic                  next_bvalid;
    logic [1:0]            next_bresp;
    // control bits {chan1_oe, chan0_oe, shared_ce}
    logic [2:0]            ctrl;
    logic [2:0]            next_ctrl;
    // read side
    logic                  next_rvalid;
    logic [1:0]            next_rresp;
    logic [31:0]           next_rdata;
    // decoded enables
    dacc_enable_type       next_chan_enable;
    logic                  chan0_output_enable;
    logic                  chan1_output_enable;
    logic                  shared_conversion_enable;
    logic [7:0]            reg_view;
    logic                  aw_hit;
    logic                  ar_hit;
    // per-channel view of the control bits; index 0 is chan0, 1 is chan1
    logic [1:0]            oe_bits;
    logic [1:0]            conv_bits;

    // named views of the three stored bits
    assign chan1_output_enable      = ctrl[2];
    assign chan0_output_enable      = ctrl[1];
    assign shared_conversion_enable = ctrl[0];
    // unused low bits always read as ones
    assign reg_view = {ctrl, UNUSED_READ}; // see [R1] see [R10]

    // register hits compare word addresses; the two low byte bits are
    // ignored so any byte address inside the word reaches the register
    assign aw_hit = aw_addr[ADDR_WIDTH-1:2] ==
                    DAC_CONTROL_ADDR[ADDR_WIDTH-1:2];
    assign ar_hit = s_axi_araddr[ADDR_WIDTH-1:2] ==
                    DAC_CONTROL_ADDR[ADDR_WIDTH-1:2];

    // each address/data half is taken once and held until the response;
    // both stay refused while bvalid is up, so one write at most is open,
    // and a read is refused only while its own answer is still waiting
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // write path: capture halves, commit when both present
    // halves may arrive in either order; the commit edge also raises
    // bvalid, so the answer comes two edges after the later half
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_byte  = w_byte;
        next_w_strb0 = w_strb0;
        next_ctrl    = ctrl;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held  = 1'b1;
            next_w_byte  = s_axi_wdata[7:0];
            next_w_strb0 = s_axi_wstrb[0];
        end
        if (aw_held && w_held) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            if (aw_hit) begin
                next_bresp = RESP_OKAY;
                // only the three control bits store; low five ignored
                // a write without lane 0 is answered but stores nothing
                if (w_strb0) begin
                    next_ctrl = {w_byte[BIT_CHAN1_OE], w_byte[BIT_CHAN0_OE],
                                 w_byte[BIT_SHARED_CE]}; // see [R1] see [R10]
                end
            end else begin
                next_bresp = RESP_SLVERR; // unmapped address
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // write path registers; bresp keeps its value between answers
    // so a held response never changes under a stalled master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= '0;
            w_byte       <= 8'h00;
            w_strb0      <= 1'b0;
            ctrl         <= CTRL_RESET; // see [R10]
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            aw_held      <= next_aw_held;
            w_held       <= next_w_held;
            aw_addr      <= next_aw_addr;
            w_byte       <= next_w_byte;
            w_strb0      <= next_w_strb0;
            ctrl         <= next_ctrl;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
        end
    end

    // read path: one-cycle answer
    // arready drops while rvalid stands, so rdata cannot be overwritten
    // before the master has taken it
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rresp  = s_axi_rresp;
        next_rdata  = s_axi_rdata;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            if (ar_hit) begin
                next_rresp = RESP_OKAY;
                next_rdata = {24'h00_0000, reg_view}; // see [R1]
            end else begin
                next_rresp = RESP_SLVERR;
                // unmapped reads return zero so nothing leaks
                next_rdata = 32'h0000_0000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // read path registers; data outputs come straight from flip-flops
    // so the bus never sees a combinational path from the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp  <= next_rresp;
            s_axi_rdata  <= next_rdata;
        end
    end

    assign oe_bits = {chan1_output_enable, chan0_output_enable};

    // a channel converts on its own output enable, or on the other
    // channel's output enable when the shared enable is set; the shared
    // enable alone never starts conversion, so an idle pair stays quiet
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        assign conv_bits[ch] = oe_bits[ch] || // see [R7] see [R8]
            (shared_conversion_enable && oe_bits[1-ch]); // see [R6] see [R9]
    end

    // drive follows the output enable alone, so a channel that converts
    // only through the shared enable keeps its analog pin off
    always_comb begin
        next_chan_enable.drive0 = oe_bits[0];   // see [R2] see [R4]
        next_chan_enable.drive1 = oe_bits[1];   // see [R3] see [R5]
        next_chan_enable.conv0  = conv_bits[0]; // see [R2]
        next_chan_enable.conv1  = conv_bits[1]; // see [R3]
    end

    // registered so the analog side sees glitch-free enables; the price
    // is one cycle between the register write and the enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_enable <= '0;
        end else begin
            chan_enable <= next_chan_enable;
        end
    end
endmodule : dacc_control
`default_nettype wire

// File: dacc_control_chk.sv
// checker: bus and enable decode properties
`timescale 1ns/1ps
`default_nettype none
module dacc_control_chk
    import dacc_pkg::*;
(
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic [1:0]      s_axi_bresp,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic [1:0]      s_axi_rresp,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire dacc_enable_type chan_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire dacc_enable_type en = chan_enable;
    // a channel that drives must also convert
    a_drive0_conv: assert property (
        en.drive0 |-> en.conv0)
        else $error("chan0 drives without conversion");
    a_drive1_conv: assert property (
        en.drive1 |-> en.conv1)
        else $error("chan1 drives without conversion");
    a_idle_off: assert property (
        !en.drive0 && !en.drive1 |-> !en.conv0 && !en.conv1)
        else $error("conversion with no output enabled");
    a_cross_conv: assert property (
        en.conv0 && !en.drive0 |-> en.drive1)
        else $error("chan0 converts with no cause");
    a_chan1_cross: assert property (
        en.conv1 && !en.drive1 |-> en.drive0)
        else $error("chan1 converts with no cause");
    // response timing and holding
    a_write_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("late write response");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    a_write_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write half accepted while response waits");
    a_unused_ones: assert property (
        s_axi_rvalid && s_axi_rresp == RESP_OKAY
        |-> s_axi_rdata[4:0] == UNUSED_READ)
        else $error("unused bits not one");
    // sync reset clears enables on the next edge
    a_reset_clear: assert property (
        disable iff (1'b0) !aresetn |=> en == 4'h0)
        else $error("enables not cleared by reset");
endmodule : dacc_control_chk
bind dacc_control dacc_control_chk i_dacc_control_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .chan_enable);
`default_nettype wire

// File: dacc_control_tb_top.sv
// testbench: axi4-lite traffic against the dac control register
`timescale 1ns/1ps
`default_nettype none
module dacc_control_tb_top
    import dacc_pkg::*;
;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic awr, wrd, bv, arr, rv;
    logic [11:0] awa = 0, ara = 0, a;
    logic [31:0] wd = 0, rd_data, d;
    logic [3:0] ws = 0;
    logic [1:0] br, rr, wq[$];
    logic [37:0] rq[$];
    logic [2:0] m = 0;
    dacc_enable_type en;
    integer seed = 43307, mismatches = 0, cmp_count = 0, cyc = 0, i;
    dacc_control i_dacc_control (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_data), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .chan_enable(en));
    task automatic chk(input string n, input logic [37:0] s, e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // readies are read mid-cycle, so the value matches the next edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, s);
        logic [2:0] h;
        wq.push_back(a == DAC_CONTROL_ADDR ? RESP_OKAY : RESP_SLVERR);
        if (a == DAC_CONTROL_ADDR && s[0]) m = d[7:5];
        @(posedge aclk);
        {awa, wd, ws} <= {a, d, s[3:0]};
        {awv, wv, bry} <= 3'h7;
        do begin
            @(negedge aclk);
            h = {awr, wrd, bv};
            @(posedge aclk);
            if (h[2]) awv <= 1'b0;
            if (h[1]) wv <= 1'b0;
        end while (!h[0]);
        bry <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic [1:0] h;
        rq.push_back({m[2] | (m[0] & m[1]), m[1] | (m[0] & m[2]), m[2], m[1],
            a == DAC_CONTROL_ADDR ? {RESP_OKAY, 24'h00_0000, m, 5'h1f} :
            {RESP_SLVERR, 32'h0000_0000}});
        @(posedge aclk);
        ara <= a;
        {arv, rry} <= 2'h3;
        do begin
            @(negedge aclk);
            h = {arr, rv};
            @(posedge aclk);
            if (h[1]) arv <= 1'b0;
        end while (!h[0]);
        rry <= 1'b0;
    endtask : rd
    task end_sim;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    initial forever #5 aclk = ~aclk;
    // monitor: oldest note against each response before its handshake edge
    always @(negedge aclk) begin
        if (bv && bry)
            chk("bresp", {36'h0, br}, {36'h0, wq.pop_front()});
        if (rv && rry)
            chk("read", {en, rr, rd_data}, rq.pop_front());
    end
    // hang guard, the run needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    // all eight enable codes first, then random lanes and addresses
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(DAC_CONTROL_ADDR);
        for (i = 0; i < 40; i++) begin
            d = $random(seed);
            a = (i < 8 || d[9]) ? DAC_CONTROL_ADDR : {d[21:12], 2'b00};
            if (i < 8) d[7:5] = i[2:0];
            wr(a, d, (i < 8) ? 32'hf : {28'h0, d[31:28]});
            rd(a);
            rd(DAC_CONTROL_ADDR);
        end
        // a reset in mid-run must clear the control bits again
        @(posedge aclk);
        aresetn <= 1'b0;
        m = 3'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(DAC_CONTROL_ADDR);
        end_sim();
    end
endmodule : dacc_control_tb_top
`default_nettype wire

// File: dacc_pkg.sv
// package: register map, field positions and reset values for dac control
`default_nettype none
package dacc_pkg;
    // printed offset 0xde is not a multiple of four: kept as index
    localparam logic [7:0]  DAC_CONTROL_INDEX = 8'hde;
    localparam logic [11:0] DAC_CONTROL_ADDR  = {2'b00, DAC_CONTROL_INDEX, 2'b00};
    localparam int          ADDR_WIDTH        = 12;
    localparam int          BIT_CHAN1_OE      = 7;
    localparam int          BIT_CHAN0_OE      = 6;
    localparam int          BIT_SHARED_CE     = 5;
    localparam logic [2:0]  CTRL_RESET        = 3'h0;
    localparam logic [4:0]  UNUSED_READ       = 5'h1f;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    // decoded enables for both channels
    typedef struct packed {
        logic conv1;
        logic conv0;
        logic drive1;
        logic drive0;
    } dacc_enable_type;
endpackage : dacc_pkg
`default_nettype wire
